// File: ubu_channel.sv
// One bridged serial channel: transmit and receive FIFOs, framing, bulk-in pacing, auto handshake.
// Assumes all inputs synchronous to CLOCK; USB engine presents bytes with valid/ready.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
module ubu_channel (
	input  wire logic       CLOCK,
	input  wire logic       RESET,
	input  wire logic       CHAN_ENABLE,
	input  wire logic [3:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WRITE,
	input  wire logic       REG_READ,
	output logic      [7:0] REG_RDATA,
	input  wire logic [7:0] OUT_DATA,
	input  wire logic       OUT_VALID,
	input  wire logic       OUT_CRC_OK,
	output logic            OUT_READY,
	input  wire logic       IN_REQUEST,
	output logic            IN_ACK,
	output logic            IN_NAK,
	output logic      [6:0] IN_COUNT,
	input  wire logic       IN_POP,
	output logic      [7:0] IN_DATA,
	output logic            TX_PIN,
	input  wire logic       RX_PIN,
	input  wire logic [5:0] AUX_IN,
	output logic      [5:0] AUX_OUT,
	output logic      [5:0] AUX_OE
);
	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]  line_r;
	logic [15:0] div_r;
	logic [2:0]  flow_r;
	logic [2:0]  pinmode_r;
	logic        wide_r;
	logic        lowlat_r;
	logic [3:0]  err_r;
	logic [23:0] baud_r;
	logic [7:0]  rdata_r;
	logic [1:0]  len;
	logic        par_en;
	logic        auto_hs;
	logic        cts_ok;
	logic [3:0]  err_set;
	logic        err_clr;
	logic        wr_baud;

	assign len     = line_r[ubu_pkg::LINE_LEN_LSB +: 2];
	assign par_en  = line_r[ubu_pkg::LINE_PAR_EN] && (len != ubu_pkg::LEN_9);  // see [R04]
	assign auto_hs = (pinmode_r == ubu_pkg::AUTO_CODE) && (flow_r == ubu_pkg::AUTO_CODE);  // see [R19]
	assign cts_ok  = !auto_hs || !AUX_IN[4];  // see [R21]
	assign err_clr = REG_READ && (REG_ADDR == ubu_pkg::REG_ERROR);
	assign wr_baud = REG_WRITE && (REG_ADDR == ubu_pkg::REG_BAUD_HI);

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			line_r    <= ubu_pkg::LINE_RESET;  // see [R17]
			div_r     <= ubu_pkg::DIV_RESET;
			flow_r    <= ubu_pkg::FLOW_RESET;
			pinmode_r <= ubu_pkg::PINMODE_RESET;
			wide_r    <= 1'b0;
			lowlat_r  <= 1'b0;
			baud_r    <= 24'h000000;
		end else if (REG_WRITE) begin
			case (REG_ADDR)
				ubu_pkg::REG_LINE:     line_r <= REG_WDATA;
				ubu_pkg::REG_DIV_LO:   div_r[7:0] <= REG_WDATA;
				ubu_pkg::REG_DIV_HI:   div_r[15:8] <= REG_WDATA;
				ubu_pkg::REG_FLOW:     flow_r <= REG_WDATA[2:0];
				ubu_pkg::REG_PINMODE:  pinmode_r <= REG_WDATA[2:0];
				ubu_pkg::REG_WIDE:     wide_r <= REG_WDATA[0];
				ubu_pkg::REG_LATENCY:  lowlat_r <= REG_WDATA[0];
				ubu_pkg::REG_BAUD_LO:  baud_r[7:0] <= REG_WDATA;
				ubu_pkg::REG_BAUD_MID: baud_r[15:8] <= REG_WDATA;
				ubu_pkg::REG_BAUD_HI: begin
					baud_r[23:16] <= REG_WDATA;
					if (wr_baud && ({REG_WDATA, baud_r[15:0]} < 24'(ubu_pkg::LOW_LAT_BAUD)))
						lowlat_r <= 1'b1;  // see [R16]
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			err_r <= 4'h0;
		else
			err_r <= (err_clr ? 4'h0 : err_r) | err_set;  // see [R12]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit FIFO
	logic [7:0] txq [ubu_pkg::TX_DEPTH];
	logic [6:0] txw_r, txr_r;
	logic [7:0] txn_r;
	logic       tx_push, tx_pop, tx_full, tx_empty;

	assign tx_full   = (txn_r == 8'(ubu_pkg::TX_DEPTH));
	assign tx_empty  = (txn_r == 8'h00);
	assign OUT_READY = CHAN_ENABLE && !tx_full;  // see [R22]
	assign tx_push   = OUT_VALID && OUT_CRC_OK && OUT_READY;  // see [R01]

	always_ff @(posedge CLOCK) begin
		if (RESET || !CHAN_ENABLE) begin
			txw_r <= 7'h00;
			txr_r <= 7'h00;
			txn_r <= 8'h00;
		end else begin
			if (tx_push) txq[txw_r] <= OUT_DATA;
			txw_r <= txw_r + 7'(tx_push);
			txr_r <= txr_r + 7'(tx_pop);
			txn_r <= txn_r + 8'(tx_push) - 8'(tx_pop);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter
	ubu_pkg::ubu_tx_t tx_st_r;
	logic [15:0] txc_r;
	logic [3:0]  txb_r;
	logic [8:0]  tsr_r;
	logic        txo_r, txpar_r, txhalf_r, tx_tick, tx_wide9, tx_ready2;
	logic [3:0]  nbits;

	assign nbits     = (len == ubu_pkg::LEN_7) ? 4'd7 : (len == ubu_pkg::LEN_8) ? 4'd8 : 4'd9;
	assign tx_tick   = (txc_r == 16'h0000);
	assign tx_wide9  = wide_r && (len == ubu_pkg::LEN_9);
	assign tx_ready2 = !tx_wide9 || (txn_r >= 8'd2);  // see [R06]
	assign tx_pop    = (tx_st_r == ubu_pkg::TX_IDLE) && !tx_empty && tx_ready2 && cts_ok && CHAN_ENABLE
	                   || txhalf_r;  // see [R02] see [R24]
	assign TX_PIN    = txo_r;

	always_ff @(posedge CLOCK) begin
		if (RESET || !CHAN_ENABLE) begin
			tx_st_r  <= ubu_pkg::TX_IDLE;
			txc_r    <= 16'h0000;
			txb_r    <= 4'h0;
			tsr_r    <= 9'h000;
			txo_r    <= 1'b1;
			txpar_r  <= 1'b0;
			txhalf_r <= 1'b0;
		end else begin
			txhalf_r <= 1'b0;
			txc_r    <= tx_tick ? div_r - 16'h0001 : txc_r - 16'h0001;
			case (tx_st_r)
				ubu_pkg::TX_IDLE: begin
					txo_r <= 1'b1;
					if (tx_pop) begin
						tsr_r    <= {1'b0, txq[txr_r]};  // see [R05]
						txhalf_r <= tx_wide9;
						txpar_r  <= line_r[ubu_pkg::LINE_PAR_ODD];
						txc_r    <= div_r - 16'h0001;
						txo_r    <= 1'b0;  // see [R03]
						txb_r    <= 4'h0;
						tx_st_r  <= ubu_pkg::TX_START;
					end
				end
				ubu_pkg::TX_START: begin
					if (txhalf_r) tsr_r[8] <= txq[txr_r][0];  // see [R06]
					if (tx_tick) begin
						txo_r   <= tsr_r[0];
						txpar_r <= txpar_r ^ tsr_r[0];
						tsr_r   <= tsr_r >> 1;
						tx_st_r <= ubu_pkg::TX_DATA;
					end
				end
				ubu_pkg::TX_DATA: if (tx_tick) begin
					txb_r <= txb_r + 4'h1;
					if (txb_r + 4'h1 == nbits) begin
						txo_r   <= par_en ? txpar_r : 1'b1;
						tx_st_r <= par_en ? ubu_pkg::TX_PAR : ubu_pkg::TX_STOP;
						txb_r   <= 4'h0;
					end else begin
						txo_r   <= tsr_r[0];
						txpar_r <= txpar_r ^ tsr_r[0];
						tsr_r   <= tsr_r >> 1;
					end
				end
				ubu_pkg::TX_PAR: if (tx_tick) begin
					txo_r   <= 1'b1;
					tx_st_r <= ubu_pkg::TX_STOP;
				end
				ubu_pkg::TX_STOP: if (tx_tick) begin
					txb_r <= txb_r + 4'h1;
					if (!line_r[ubu_pkg::LINE_STOP2] || txb_r == 4'h1)
						tx_st_r <= ubu_pkg::TX_IDLE;
				end
				default: tx_st_r <= ubu_pkg::TX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive FIFO
	logic [7:0] rxq [ubu_pkg::RX_DEPTH];
	logic [8:0] rxw_r, rxr_r, rxn_r;
	logic       rx_push, rx_full;
	logic [7:0] rx_pdata;
	logic       rx_take;

	assign rx_full = (rxn_r == 9'(ubu_pkg::RX_DEPTH));
	assign rx_take = IN_POP && (rxn_r != 9'h000);

	always_ff @(posedge CLOCK) begin
		if (RESET || !CHAN_ENABLE) begin
			rxw_r <= 9'h000;
			rxr_r <= 9'h000;
			rxn_r <= 9'h000;
		end else begin
			if (rx_push && !rx_full) rxq[rxw_r] <= rx_pdata;  // see [R07]
			if (rx_push && !rx_full)
				rxw_r <= (rxw_r == 9'(ubu_pkg::RX_DEPTH - 1)) ? 9'h000 : rxw_r + 9'h001;
			if (rx_take)
				rxr_r <= (rxr_r == 9'(ubu_pkg::RX_DEPTH - 1)) ? 9'h000 : rxr_r + 9'h001;
			rxn_r <= rxn_r + 9'(rx_push && !rx_full) - 9'(rx_take);
		end
	end

	assign IN_DATA = rxq[rxr_r];

	////////////////////////////////////////////////////////////////////////////////
	// Receiver
	ubu_pkg::ubu_rx_t rx_st_r;
	logic [15:0] rxc_r;
	logic [3:0]  rxb_r;
	logic [8:0]  rsr_r;
	logic        rxpar_r, rxbrk_r;
	logic [7:0]  stat_r;
	logic        rx_tick, rx_wide, rx_done;
	logic [7:0]  rx_byte;
	logic [3:0]  flags;

	assign rx_tick = (rxc_r == 16'h0000);
	assign rx_wide = wide_r;
	assign rx_done = (rx_st_r == ubu_pkg::RX_STOP) && rx_tick;
	assign rx_byte = (len == ubu_pkg::LEN_9) ? rsr_r[7:0] : (len == ubu_pkg::LEN_8) ? rsr_r[8:1]
	                 : {1'b0, rsr_r[8:2]};
	assign flags[ubu_pkg::ST_PAR] = (len == ubu_pkg::LEN_9) ? rsr_r[8] : (par_en && rxpar_r);  // see [R11]
	assign flags[ubu_pkg::ST_BRK] = rxbrk_r && !RX_PIN;
	assign flags[ubu_pkg::ST_FRM] = !RX_PIN;
	assign flags[ubu_pkg::ST_OVR] = rx_full;
	assign err_set  = rx_done ? {flags[3:1], par_en && rxpar_r} : 4'h0;
	assign rx_push  = rx_done || (rx_st_r == ubu_pkg::RX_PUSH2);  // see [R08] see [R09]
	assign rx_pdata = (rx_st_r == ubu_pkg::RX_PUSH2) ? stat_r : rx_byte;  // see [R10]

	always_ff @(posedge CLOCK) begin
		if (RESET || !CHAN_ENABLE) begin
			rx_st_r <= ubu_pkg::RX_IDLE;
			rxc_r   <= 16'h0000;
			rxb_r   <= 4'h0;
			rsr_r   <= 9'h000;
			rxpar_r <= 1'b0;
			rxbrk_r <= 1'b0;
			stat_r  <= 8'h00;
		end else begin
			rxc_r <= rx_tick ? div_r - 16'h0001 : rxc_r - 16'h0001;
			case (rx_st_r)
				ubu_pkg::RX_IDLE: if (!RX_PIN) begin
					rxc_r   <= {1'b0, div_r[15:1]};
					rx_st_r <= ubu_pkg::RX_START;
				end
				ubu_pkg::RX_START: if (rx_tick) begin
					rx_st_r <= RX_PIN ? ubu_pkg::RX_IDLE : ubu_pkg::RX_DATA;
					rxb_r   <= 4'h0;
					rxpar_r <= line_r[ubu_pkg::LINE_PAR_ODD];
					rxbrk_r <= 1'b1;
				end
				ubu_pkg::RX_DATA: if (rx_tick) begin
					rsr_r   <= {RX_PIN, rsr_r[8:1]};
					rxpar_r <= rxpar_r ^ RX_PIN;
					rxbrk_r <= rxbrk_r && !RX_PIN;
					rxb_r   <= rxb_r + 4'h1;
					if (rxb_r + 4'h1 == nbits)
						rx_st_r <= par_en ? ubu_pkg::RX_PAR : ubu_pkg::RX_STOP;
				end
				ubu_pkg::RX_PAR: if (rx_tick) begin
					rxpar_r <= rxpar_r ^ RX_PIN;
					rxbrk_r <= rxbrk_r && !RX_PIN;
					rx_st_r <= ubu_pkg::RX_STOP;
				end
				ubu_pkg::RX_STOP: if (rx_tick) begin
					stat_r  <= {4'h0, flags};
					rx_st_r <= rx_wide ? ubu_pkg::RX_PUSH2 : ubu_pkg::RX_IDLE;
				end
				ubu_pkg::RX_PUSH2: rx_st_r <= ubu_pkg::RX_IDLE;
				default: rx_st_r <= ubu_pkg::RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bulk-in pacing
	logic [15:0] idc_r;
	logic [5:0]  idb_r;
	logic [5:0]  chbits;
	logic        idle_long, pkt_full;

	assign chbits    = 6'(nbits) + 6'(par_en) + 6'(line_r[ubu_pkg::LINE_STOP2]) + 6'd2;
	assign idle_long = (idb_r > chbits * ubu_pkg::IDLE_CHARS);
	assign pkt_full  = (rxn_r >= ubu_pkg::PKT_SIZE);
	assign IN_ACK    = IN_REQUEST && (rxn_r != 9'h000) && (pkt_full || lowlat_r || idle_long);  // see [R13] see [R14] see [R15]
	assign IN_NAK    = IN_REQUEST && !IN_ACK;
	assign IN_COUNT  = pkt_full ? 7'(ubu_pkg::PKT_SIZE) : 7'(rxn_r);

	always_ff @(posedge CLOCK) begin
		if (RESET || rx_st_r != ubu_pkg::RX_IDLE) begin
			idc_r <= 16'h0000;
			idb_r <= 6'h00;
		end else if (idc_r == div_r) begin
			idc_r <= 16'h0000;
			if (idb_r != 6'h3f) idb_r <= idb_r + 6'h01;
		end else begin
			idc_r <= idc_r + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Handshake pins
	logic rts_r;

	always_ff @(posedge CLOCK) begin
		if (RESET)
			rts_r <= 1'b1;
		else if (rxn_r >= ubu_pkg::RTS_HIGH)
			rts_r <= 1'b0;  // see [R20] see [R23]
		else if (rxn_r < ubu_pkg::RTS_LOW)
			rts_r <= 1'b1;
	end

	assign AUX_OUT = {!(rts_r && auto_hs), 5'h00};
	assign AUX_OE  = {auto_hs, 5'h00};  // see [R18]

	always_ff @(posedge CLOCK) begin
		if (RESET)
			rdata_r <= 8'h00;
		else if (REG_READ) begin
			case (REG_ADDR)
				ubu_pkg::REG_LINE:    rdata_r <= line_r;
				ubu_pkg::REG_DIV_LO:  rdata_r <= div_r[7:0];
				ubu_pkg::REG_DIV_HI:  rdata_r <= div_r[15:8];
				ubu_pkg::REG_FLOW:    rdata_r <= {5'h00, flow_r};
				ubu_pkg::REG_PINMODE: rdata_r <= {5'h00, pinmode_r};
				ubu_pkg::REG_WIDE:    rdata_r <= {7'h00, wide_r};
				ubu_pkg::REG_LATENCY: rdata_r <= {7'h00, lowlat_r};
				ubu_pkg::REG_ERROR:   rdata_r <= {4'h0, err_r | err_set};
				ubu_pkg::REG_PINS:    rdata_r <= {2'h0, AUX_IN};
				ubu_pkg::REG_STATUS:  rdata_r <= {6'h00, tx_st_r != ubu_pkg::TX_IDLE, rts_r};
				default:              rdata_r <= 8'h00;
			endcase
		end else
			rdata_r <= 8'h00;
	end

	assign REG_RDATA = rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	hs_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
		!auto_hs |-> AUX_OE == 6'h00) else $error("aux pin driven without handshake");  // see [R19]
	tx_hold_a: assert property (@(posedge CLOCK) disable iff (RESET)
		(auto_hs && AUX_IN[4] && tx_st_r == ubu_pkg::TX_IDLE) |=> tx_st_r == ubu_pkg::TX_IDLE)
		else $error("transmit started while clear inactive");  // see [R24]
	ack_rule_a: assert property (@(posedge CLOCK) disable iff (RESET)
		(IN_REQUEST && pkt_full) |-> IN_ACK && IN_COUNT == 7'd64) else $error("full packet not sent");  // see [R13]
	lowlat_a: assert property (@(posedge CLOCK) disable iff (RESET)
		(IN_REQUEST && lowlat_r && rxn_r != 9'h000) |-> IN_ACK) else $error("low latency not honoured");  // see [R15]
	rts_drop_a: assert property (@(posedge CLOCK) disable iff (RESET)
		(rxn_r >= ubu_pkg::RTS_HIGH) |=> !rts_r) else $error("request not dropped");  // see [R20]
	err_sticky_a: assert property (@(posedge CLOCK) disable iff (RESET)
		(err_r != 4'h0 && !err_clr) |=> (err_r & $past(err_r)) == $past(err_r)) else $error("error lost");  // see [R12]
	start_bit_a: assert property (@(posedge CLOCK) disable iff (RESET)
		(tx_st_r == ubu_pkg::TX_IDLE && tx_pop) |=> !TX_PIN) else $error("no start bit");  // see [R03]
	crc_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
		(OUT_VALID && !OUT_CRC_OK) |=> txn_r <= $past(txn_r)) else $error("bad packet stored");  // see [R01]
endmodule

// File: ubu_pkg.sv
// Constants for one bridged serial channel: register map, fields, resets, timing.
// Assumes a 10 MHz core clock and a plain address/strobe register port.
// Notes on behaviour
// [R01] Bulk-out bytes enter a 128-byte transmit FIFO only after a good packet CRC.
// [R02] Next byte loads into the transmit shift register when idle or just finished.
// [R03] Frame: start, data LSB first, optional parity, then one or two stop bits.
// [R04] Character length is 7 or 8 bits with optional parity, or 9 without.
// [R05] Nine-bit characters without the two-byte format send bit eight as zero.
// [R06] Two-byte nine-bit transmit takes low byte then bit eight in next byte.
// [R07] Received characters go through a receive shift register into a 384-byte FIFO.
// [R08] Normal 7/8-bit receive stores only the data byte, errors dropped.
// [R09] Normal 9-bit receive stores the low eight bits, the rest dropped.
// [R10] Two-byte 7/8-bit receive stores data then status: parity, break, framing, overrun.
// [R11] Two-byte 9-bit receive stores low byte then status with bit eight in bit 0.
// [R12] Error status flags are sticky until read, set wins over clear.
// [R13] Bulk-in answers with a full 64-byte packet once 64 bytes are buffered.
// [R14] Fewer bytes are sent after more than three idle character times.
// [R15] Low-latency bit sends any buffered data at the next bulk-in request.
// [R16] Line-coding baud below 46921 sets low-latency mode automatically.
// [R17] Reset state: 9600 baud, 8 bits, no parity, one stop, no flow control.
// [R18] Six auxiliary pins, all inputs after reset.
// [R19] Auto handshake only when pin mode and flow mode both equal 001.
// [R20] Request output drops when the receive FIFO risks overrun, returns with room.
// [R21] Clear input pauses and resumes the transmitter; remote drives it.
// [R22] Channel and its FIFOs are enabled by a separate manager control.
// [R23] Request drops above a high threshold, returns below a low threshold.
// [R24] Clear inactive lets the current character finish, then holds new ones.
package ubu_pkg;
	localparam logic [3:0]  REG_LINE      = 4'h0;
	localparam logic [3:0]  REG_DIV_LO    = 4'h1;
	localparam logic [3:0]  REG_DIV_HI    = 4'h2;
	localparam logic [3:0]  REG_FLOW      = 4'h3;
	localparam logic [3:0]  REG_PINMODE   = 4'h4;
	localparam logic [3:0]  REG_WIDE      = 4'h5;
	localparam logic [3:0]  REG_LATENCY   = 4'h6;
	localparam logic [3:0]  REG_ERROR     = 4'h7;
	localparam logic [3:0]  REG_PINS      = 4'h8;
	localparam logic [3:0]  REG_BAUD_LO   = 4'h9;
	localparam logic [3:0]  REG_BAUD_MID  = 4'ha;
	localparam logic [3:0]  REG_BAUD_HI   = 4'hb;
	localparam logic [3:0]  REG_STATUS    = 4'hc;
	// Line register fields
	localparam int          LINE_LEN_LSB  = 0;
	localparam int          LINE_PAR_EN   = 2;
	localparam int          LINE_PAR_ODD  = 3;
	localparam int          LINE_STOP2    = 4;
	localparam logic [1:0]  LEN_7         = 2'h0;
	localparam logic [1:0]  LEN_8         = 2'h1;
	localparam logic [1:0]  LEN_9         = 2'h2;
	localparam logic [7:0]  LINE_RESET    = 8'h01;
	localparam logic [2:0]  AUTO_CODE     = 3'h1;
	localparam logic [2:0]  FLOW_RESET    = 3'h0;
	localparam logic [2:0]  PINMODE_RESET = 3'h0;
	localparam int          CLK_HZ        = 10000000;
	localparam int          BAUD_RESET    = 9600;
	localparam int          LOW_LAT_BAUD  = 46921;
	localparam logic [15:0] DIV_RESET     = 16'((CLK_HZ + BAUD_RESET / 2) / BAUD_RESET);
	// FIFO sizes and levels
	localparam int          TX_DEPTH      = 128;
	localparam int          RX_DEPTH      = 384;
	localparam logic [8:0]  PKT_SIZE      = 9'd64;
	localparam logic [8:0]  RTS_HIGH      = 9'd352;
	localparam logic [8:0]  RTS_LOW       = 9'd256;
	localparam logic [5:0]  IDLE_CHARS    = 6'd3;
	localparam int          ST_PAR        = 0;
	localparam int          ST_BRK        = 1;
	localparam int          ST_FRM        = 2;
	localparam int          ST_OVR        = 3;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ubu_tx_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_PUSH2} ubu_rx_t;
endpackage

// File: ubu_remote.sv
// Remote serial partner: frames bytes onto the channel's receive line, decodes its transmit line.
// Assumes the bit time in core clocks comes from bit_div; idle lines rest high.
`timescale 1ns/100ps
module ubu_remote (
	input  wire logic        clk,
	input  wire logic [15:0] bit_div,
	input  wire logic [3:0]  nbits,
	input  wire logic        line_in,
	output logic             line_out,
	output logic [9:0]       got_bits,
	output int               got_count
);
	initial begin
		line_out = 1'b1;
		got_bits = '0;
		got_count = 0;
	end
	////////////////////////////////////////////////////////////////
	// Frame out: start, bits LSB first, given stop level, idle high
	task automatic send(input logic [9:0] bits, input int n, input logic stop);
		@(posedge clk) line_out <= 1'b0;
		repeat (bit_div) @(posedge clk);
		for (int b = 0; b < n; b++) begin
			line_out <= bits[b];
			repeat (bit_div) @(posedge clk);
		end
		line_out <= stop;
		repeat (bit_div) @(posedge clk);
		line_out <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////
	// Frame in: mid-bit samples, stop level lands in bit nbits
	always begin
		logic [9:0] f;
		@(negedge line_in);
		f = '0;
		repeat (bit_div / 2) @(posedge clk);
		for (int b = 0; b <= nbits; b++) begin
			repeat (bit_div) @(posedge clk);
			f[b] = line_in;
		end
		got_bits <= f;
		got_count <= got_count + 1;
	end
endmodule

// File: tb_ubu_channel.sv
// Bench for one bridged serial channel: registers, bulk transfers, framing, handshake.
// Assumes the remote partner model on the serial pins and a 10 MHz clock.
`timescale 1ns/100ps
module tb_ubu_channel;
	logic       clk, rst, chan_en, reg_wr, reg_rd, out_valid, out_crc, in_req, in_pop;
	logic       out_ready, in_ack, in_nak, tx_pin, rx_pin;
	logic [3:0] reg_addr, nbits;
	logic [7:0] reg_wdata, reg_rdata, out_data, in_data;
	logic [6:0] in_count;
	logic [5:0] aux_drv, aux_out, aux_oe;
	wire  [5:0] aux_in = (aux_oe & aux_out) | (~aux_oe & aux_drv);
	logic [9:0] got_bits;
	int         got_count, num_errors, check_count, cyc, tx_seen, i, k;
	logic [7:0] exp_q[$];

	ubu_channel i_ubu_channel (.CLOCK(clk), .RESET(rst), .CHAN_ENABLE(chan_en), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WRITE(reg_wr), .REG_READ(reg_rd), .REG_RDATA(reg_rdata),
		.OUT_DATA(out_data), .OUT_VALID(out_valid), .OUT_CRC_OK(out_crc), .OUT_READY(out_ready),
		.IN_REQUEST(in_req), .IN_ACK(in_ack), .IN_NAK(in_nak), .IN_COUNT(in_count), .IN_POP(in_pop),
		.IN_DATA(in_data), .TX_PIN(tx_pin), .RX_PIN(rx_pin), .AUX_IN(aux_in), .AUX_OUT(aux_out),
		.AUX_OE(aux_oe));
	ubu_remote i_ubu_remote (.clk(clk), .bit_div(16'h0008), .nbits(nbits), .line_in(tx_pin),
		.line_out(rx_pin), .got_bits(got_bits), .got_count(got_count));

	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	task print_verdict;
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
	endtask
	task push(input logic [7:0] d, input logic ok);
		@(posedge clk);
		out_data <= d;
		out_valid <= 1'b1;
		out_crc <= ok;
		@(posedge clk);
		out_valid <= 1'b0;
	endtask
	task tx_chk(input logic [9:0] e);
		tx_seen++;
		for (k = 0; k < 3000 && got_count < tx_seen; k++) @(posedge clk);
		@(negedge clk);
		chk(got_bits, e);
	endtask
	task bulk(input int n);
		@(posedge clk) in_req <= 1'b1;
		@(negedge clk);
		for (k = 0; k < 600 && in_ack !== 1'b1; k++) @(negedge clk);
		chk(in_count, n[6:0]);
		for (int j = 0; j < n; j++) begin
			chk(in_data, exp_q.pop_front());
			@(posedge clk) in_pop <= 1'b1;
			@(posedge clk) in_pop <= 1'b0;
			@(negedge clk);
		end
		@(posedge clk) in_req <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		chan_en = 1'b1;
		{reg_wr, reg_rd, out_valid, out_crc, in_req, in_pop} = '0;
		{reg_addr, reg_wdata, out_data} = '0;
		aux_drv = 6'h3f;
		nbits = 4'h8;
		{num_errors, check_count, cyc, tx_seen} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(ubu_pkg::REG_LINE, 8'h01);
		rd(ubu_pkg::REG_DIV_LO, 8'h12);
		rd(ubu_pkg::REG_DIV_HI, 8'h04);
		rd(ubu_pkg::REG_FLOW, 8'h00);
		rd(4'hd, 8'h00);
		rd(ubu_pkg::REG_PINS, 8'h3f);
		rd(ubu_pkg::REG_STATUS, 8'h01);
		chk(aux_oe, 6'h00);
		chk(tx_pin, 1'b1);
		wr(ubu_pkg::REG_DIV_LO, 8'h08);
		wr(ubu_pkg::REG_DIV_HI, 8'h00);
		push(8'hee, 1'b0);
		repeat (300) @(posedge clk);
		chk(16'(got_count), 16'h0000);
		push(8'h3c, 1'b1);
		push(8'hc3, 1'b1);
		tx_chk(10'h13c);
		tx_chk(10'h1c3);
		wr(ubu_pkg::REG_LINE, 8'h11);
		nbits = 4'h9;
		push(8'ha5, 1'b1);
		push(8'h5a, 1'b1);
		tx_chk(10'h3a5);
		tx_chk(10'h35a);
		wr(ubu_pkg::REG_LINE, 8'h0d);
		push(8'h03, 1'b1);
		tx_chk(10'h303);
		wr(ubu_pkg::REG_LINE, 8'h00);
		nbits = 4'h7;
		push(8'hff, 1'b1);
		tx_chk(10'h0ff);
		wr(ubu_pkg::REG_LINE, 8'h02);
		nbits = 4'h9;
		push(8'h81, 1'b1);
		tx_chk(10'h281);
		wr(ubu_pkg::REG_WIDE, 8'h01);
		push(8'h5a, 1'b1);
		push(8'h01, 1'b1);
		tx_chk(10'h35a);
		wr(ubu_pkg::REG_LATENCY, 8'h01);
		i_ubu_remote.send(10'h1a5, 9, 1'b1);
		exp_q = '{8'ha5, 8'h01};
		bulk(2);
		wr(ubu_pkg::REG_LINE, 8'h05);
		i_ubu_remote.send(10'h001, 9, 1'b1);
		exp_q = '{8'h01, 8'h01};
		bulk(2);
		wr(ubu_pkg::REG_LINE, 8'h01);
		nbits = 4'h8;
		i_ubu_remote.send(10'h055, 8, 1'b0);
		exp_q = '{8'h55, 8'h04};
		bulk(2);
		wr(ubu_pkg::REG_WIDE, 8'h00);
		i_ubu_remote.send(10'h055, 8, 1'b0);
		exp_q = '{8'h55};
		bulk(1);
		rd(ubu_pkg::REG_ERROR, 8'h05);
		rd(ubu_pkg::REG_ERROR, 8'h00);
		wr(ubu_pkg::REG_LINE, 8'h02);
		i_ubu_remote.send(10'h1a5, 9, 1'b1);
		exp_q = '{8'ha5};
		bulk(1);
		wr(ubu_pkg::REG_LINE, 8'h01);
		wr(ubu_pkg::REG_LATENCY, 8'h00);
		i_ubu_remote.send(10'h096, 8, 1'b1);
		@(posedge clk) in_req <= 1'b1;
		@(negedge clk) chk(in_nak, 1'b1);
		chk(in_ack, 1'b0);
		@(posedge clk) in_req <= 1'b0;
		exp_q = '{8'h96};
		bulk(1);
		@(posedge clk) aux_drv <= 6'h2f;
		wr(ubu_pkg::REG_FLOW, 8'h01);
		wr(ubu_pkg::REG_PINMODE, 8'h01);
		@(negedge clk) chk(aux_oe[5], 1'b1);
		chk(aux_out[5], 1'b0);
		push(8'h11, 1'b1);
		push(8'h22, 1'b1);
		for (k = 0; k < 300 && tx_pin !== 1'b0; k++) @(negedge clk);
		@(posedge clk) aux_drv[4] <= 1'b1;
		tx_chk(10'h111);
		repeat (300) @(posedge clk);
		chk(16'(got_count), 16'(tx_seen));
		aux_drv[4] <= 1'b0;
		tx_chk(10'h122);
		for (i = 0; i < 353; i++) begin
			i_ubu_remote.send({2'b00, i[7:0]}, 8, 1'b1);
			exp_q.push_back(i[7:0]);
		end
		@(negedge clk) chk(aux_out[5], 1'b1);
		bulk(64);
		@(negedge clk) chk(aux_out[5], 1'b1);
		bulk(64);
		@(negedge clk) chk(aux_out[5], 1'b0);
		repeat (3) bulk(64);
		bulk(33);
		@(posedge clk) chan_en <= 1'b0;
		@(negedge clk) chk(out_ready, 1'b0);
		@(posedge clk) chan_en <= 1'b1;
		wr(ubu_pkg::REG_BAUD_LO, 8'h48);
		wr(ubu_pkg::REG_BAUD_MID, 8'hb7);
		wr(ubu_pkg::REG_BAUD_HI, 8'h00);
		rd(ubu_pkg::REG_LATENCY, 8'h01);
		wr(ubu_pkg::REG_LATENCY, 8'h00);
		wr(ubu_pkg::REG_BAUD_LO, 8'h49);
		wr(ubu_pkg::REG_BAUD_MID, 8'hb7);
		wr(ubu_pkg::REG_BAUD_HI, 8'h00);
		rd(ubu_pkg::REG_LATENCY, 8'h00);
		print_verdict();
	end
endmodule
